// file: rtl/mag_meas_top.sv
// Operation
// - one eight-bit command configures and starts a measurement of a single axis.
// - time the period count with a 2 MHz internal clock, per bias direction.
// - result is the signed 16-bit difference of forward and reverse times.
// - bias forward and count, bias reverse and count, then subtract.
// - data lines change only while serial clock is low.
// - command bits: clock test, period select, test direction, continuous test, axis.
// - axis codes 0 and 1 give X, 2 gives Y, 3 gives Z.
// - period count doubles per code, 32 up to 4096.
// - at 4096 periods the time counter may overflow.
// - continuous test runs the selected oscillator until the next reset.
// - test direction bit only matters when continuous test is set.
// - clock test pad shows internal clock halved when enabled, else high.
// - idle when not transferring or measuring, only after a first measurement.
// - start executing once the eighth command bit is in.
// - raise result ready when the measurement finishes.
// - master gives 16 clocks; device shifts the result out meanwhile.
// - command and result travel most significant bit first.
// - data output floats while select is high.
// - result ready low after reset until the data exists.
// - sample on rising serial clock, change output on falling.
module mag_meas_top #(
  parameter int HS_DIV = mag_pkg::HS_DIV
) (
  input  wire logic                     i_clock,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_sclk,
  input  wire logic                     i_mosi,
  input  wire logic                     i_device_select_n,
  input  wire logic                     i_reset,
  input  wire logic [mag_pkg::AXES-1:0] i_osc_comp,
  output logic                          o_miso,
  output logic                          o_miso_oe,
  output logic                          o_result_ready,
  output logic                          o_clock_test_output,
  output logic                          o_bias_forward,
  output logic      [mag_pkg::AXES-1:0] o_osc_enable,
  output logic                          o_idle
);
  import mag_pkg::*;

  localparam int HS_CNT_W = $clog2(HS_DIV);

  logic [SYNC_W-1:0]   sync_lvl;
  logic                sclk_s;
  logic                mosi_s;
  logic                sel_n_s;
  logic                dev_reset;
  logic [AXES-1:0]     osc_s;
  logic                sclk_prev;
  logic                sclk_rise;
  logic                sclk_fall;
  logic [HS_CNT_W-1:0] hs_cnt;
  logic                hs_tick;
  logic                hs_half;
  mag_state_e          state;
  logic [CMD_W-1:0]    cmd;
  logic [CMD_W-1:0]    cmd_shift;
  logic [CMD_W-1:0]    next_cmd;
  logic [BITCNT_W-1:0] bit_cnt;
  logic [AXES-1:0]     axis_en;
  logic                osc_sel;
  logic                timer_start;
  logic                timer_done;
  logic [RES_W-1:0]    timer_time;
  logic [RES_W-1:0]    fwd_time;
  logic [RES_W-1:0]    diff;
  logic [RES_W-1:0]    res_shift;
  logic                seen_meas;

  mag_sync #(
    .WIDTH   (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_clock (i_clock),
    .i_rst_n (i_rst_n),
    .i_async ({i_osc_comp, i_reset, i_device_select_n, i_mosi, i_sclk}),
    .o_level (sync_lvl)
  );

  assign sclk_s    = sync_lvl[0];
  assign mosi_s    = sync_lvl[1];
  assign sel_n_s   = sync_lvl[2];
  assign dev_reset = sync_lvl[3];
  assign osc_s     = sync_lvl[6:4];

  // serial edges only count while selected
  assign sclk_rise = sclk_s & ~sclk_prev & ~sel_n_s;
  assign sclk_fall = ~sclk_s & sclk_prev & ~sel_n_s;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  // internal high-speed clock as a tick, so every flop stays on i_clock
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hs_cnt  <= '0;
      hs_tick <= 1'b0;
    end else if (hs_cnt == HS_CNT_W'(HS_DIV - 1)) begin
      hs_cnt  <= '0;
      hs_tick <= 1'b1;
    end else begin
      hs_cnt  <= hs_cnt + 1'b1;
      hs_tick <= 1'b0;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      hs_half             <= 1'b0;
      o_clock_test_output <= 1'b1;
    end else begin
      if (hs_tick) begin
        hs_half <= ~hs_half;
      end
      o_clock_test_output <= cmd[CMD_CLK_TEST] ? hs_half : 1'b1;
    end
  end

  assign next_cmd = {cmd_shift[CMD_W-2:0], mosi_s};

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || dev_reset) begin
      state     <= ST_WAIT_CMD;
      cmd       <= CMD_RESET;
      cmd_shift <= CMD_RESET;
      bit_cnt   <= '0;
    end else begin
      unique case (state)
        ST_WAIT_CMD: begin
          if (sel_n_s) begin
            // a byte cut short by deselect is dropped, not resumed
            bit_cnt <= '0;
          end else if (sclk_rise) begin
            cmd_shift <= next_cmd;
            if (bit_cnt == CMD_BITS - 5'h01) begin
              cmd     <= next_cmd;
              bit_cnt <= '0;
              if (next_cmd[CMD_CONT_TEST]) begin
                state <= ST_CONT_TEST;
              end else begin
                state <= ST_FWD_START;
              end
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
            end
          end
        end
        ST_FWD_START: begin
          state <= ST_FWD;
        end
        ST_FWD: begin
          if (timer_done) begin
            state <= ST_REV_START;
          end
        end
        ST_REV_START: begin
          state <= ST_REV;
        end
        ST_REV: begin
          if (timer_done) begin
            state <= ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (sclk_rise) begin
            if (bit_cnt == RES_BITS - 5'h01) begin
              bit_cnt <= '0;
              state   <= ST_SLEEP;
            end else begin
              bit_cnt <= bit_cnt + 1'b1;
            end
          end
        end
        ST_SLEEP: begin
          // a new command needs the reset pin first
          state <= ST_SLEEP;
        end
        ST_CONT_TEST: begin
          // left only by the reset pin
          state <= ST_CONT_TEST;
        end
      endcase
    end
  end

  assign axis_en     = axis_onehot(cmd[CMD_AXIS_HI:CMD_AXIS_LO]);
  assign osc_sel     = |(axis_onehot(cmd[CMD_AXIS_HI:CMD_AXIS_LO]) & osc_s);
  assign timer_start = (state == ST_FWD_START) || (state == ST_REV_START);

  // one timer serves both directions; forward time is parked in fwd_time
  mag_osc_timer #(
    .CNT_W  (PCNT_W),
    .TIME_W (RES_W)
  ) u_timer (
    .i_clock   (i_clock),
    .i_rst_n   (i_rst_n),
    .i_abort   (dev_reset),
    .i_start   (timer_start),
    .i_osc     (osc_sel),
    .i_tick    (hs_tick),
    .i_periods (period_count(cmd[CMD_PS_HI:CMD_PS_LO])),
    .o_done    (timer_done),
    .o_time    (timer_time)
  );

  assign diff = fwd_time - timer_time;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || dev_reset) begin
      fwd_time  <= '0;
      res_shift <= '0;
      o_miso    <= 1'b0;
    end else begin
      if (state == ST_FWD && timer_done) begin
        fwd_time <= timer_time;
      end
      if (state == ST_REV && timer_done) begin
        res_shift <= diff;
        o_miso    <= diff[RES_W-1];
      end else if ((state == ST_RESULT || state == ST_SLEEP) && sclk_fall) begin
        // the last bit is cleared by the fall after the sixteenth rise, never while sclk is high
        res_shift <= {res_shift[RES_W-2:0], 1'b0};
        o_miso    <= res_shift[RES_W-2];
      end else if (state != ST_RESULT && state != ST_SLEEP) begin
        // the command byte sees a steady low; the host ignores it anyway
        o_miso <= 1'b0;
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_miso_oe <= 1'b0;
    end else begin
      o_miso_oe <= ~sel_n_s;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || dev_reset) begin
      o_result_ready <= 1'b0;
    end else if (state == ST_REV && timer_done) begin
      o_result_ready <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_osc_enable   <= '0;
      o_bias_forward <= 1'b0;
    end else begin
      unique case (state)
        ST_FWD_START, ST_FWD: begin
          o_osc_enable   <= axis_en;
          o_bias_forward <= 1'b1;
        end
        ST_REV_START, ST_REV: begin
          o_osc_enable   <= axis_en;
          o_bias_forward <= 1'b0;
        end
        ST_CONT_TEST: begin
          o_osc_enable   <= axis_en;
          o_bias_forward <= cmd[CMD_TEST_DIR];
        end
        ST_WAIT_CMD, ST_RESULT, ST_SLEEP: begin
          o_osc_enable   <= '0;
          o_bias_forward <= 1'b0;
        end
      endcase
    end
  end

  // the pin reset does not clear this: only power-on state is uncertain
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      seen_meas <= 1'b0;
    end else if (state == ST_REV && timer_done) begin
      seen_meas <= 1'b1;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_idle <= 1'b0;
    end else begin
      o_idle <= seen_meas
        && (state == ST_SLEEP || (state == ST_WAIT_CMD && bit_cnt == '0));
    end
  end
endmodule

// file: common/mag_pkg.sv
package mag_pkg;
  localparam int             CMD_W         = 8;
  localparam int             RES_W         = 16;
  localparam int             PCNT_W        = 13;
  localparam int             AXES          = 3;
  localparam int             BITCNT_W      = 5;
  localparam int             SYNC_W        = 7;
  localparam int             CMD_CLK_TEST  = 7;
  localparam int             CMD_PS_HI     = 6;
  localparam int             CMD_PS_LO     = 4;
  localparam int             CMD_TEST_DIR  = 3;
  localparam int             CMD_CONT_TEST = 2;
  localparam int             CMD_AXIS_HI   = 1;
  localparam int             CMD_AXIS_LO   = 0;
  localparam logic [7:0]     CMD_RESET     = 8'h00;
  localparam logic [12:0]    PERIOD_BASE   = 13'h0020;
  localparam logic [1:0]     AXIS_X0       = 2'h0;
  localparam logic [1:0]     AXIS_X1       = 2'h1;
  localparam logic [1:0]     AXIS_Y        = 2'h2;
  localparam logic [1:0]     AXIS_Z        = 2'h3;
  localparam logic [4:0]     CMD_BITS      = 5'h08;
  localparam logic [4:0]     RES_BITS      = 5'h10;
  // sync vector order {osc_comp[2:0], reset, select_n, mosi, sclk}
  localparam logic [6:0]     SYNC_RST      = 7'h04;
  localparam int             CLK_HZ        = 20_000_000;
  localparam int             HS_CLK_HZ     = 2_000_000;
  localparam int             HS_DIV        = CLK_HZ / HS_CLK_HZ;

  typedef enum logic [2:0] {
    ST_WAIT_CMD,
    ST_FWD_START,
    ST_FWD,
    ST_REV_START,
    ST_REV,
    ST_RESULT,
    ST_SLEEP,
    ST_CONT_TEST
  } mag_state_e;

  function automatic logic [12:0] period_count(input logic [2:0] sel);
    period_count = PERIOD_BASE << sel;
  endfunction

  function automatic logic [2:0] axis_onehot(input logic [1:0] sel);
    unique case (sel)
      AXIS_X0: axis_onehot = 3'h1;
      AXIS_X1: axis_onehot = 3'h1;
      AXIS_Y:  axis_onehot = 3'h2;
      AXIS_Z:  axis_onehot = 3'h4;
    endcase
  endfunction
endpackage

// file: rtl/mag_sync.sv
module mag_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             i_clock,
  input  wire logic             i_rst_n,
  input  wire logic [WIDTH-1:0] i_async,
  output logic      [WIDTH-1:0] o_level
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;
  logic [WIDTH-1:0] agree;

  assign agree = ~(stage2 ^ stage3);

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      meta   <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      meta   <= i_async;
      stage2 <= meta;
      stage3 <= stage2;
    end
  end

  // a bit only moves once two settled stages agree, which rejects one-cycle glitches
  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      o_level <= RST_VAL;
    end else begin
      o_level <= (o_level & ~agree) | (stage2 & agree);
    end
  end
endmodule

// file: rtl/mag_osc_timer.sv
module mag_osc_timer #(
  parameter int CNT_W  = 13,
  parameter int TIME_W = 16
) (
  input  wire logic              i_clock,
  input  wire logic              i_rst_n,
  input  wire logic              i_abort,
  input  wire logic              i_start,
  input  wire logic              i_osc,
  input  wire logic              i_tick,
  input  wire logic [CNT_W-1:0]  i_periods,
  output logic                   o_done,
  output logic      [TIME_W-1:0] o_time
);
  logic             osc_prev;
  logic             busy;
  logic [CNT_W-1:0] edges;
  logic             osc_rise;

  assign osc_rise = i_osc & ~osc_prev;

  always_ff @(posedge i_clock) begin
    if (!i_rst_n) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= i_osc;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_rst_n || i_abort) begin
      busy   <= 1'b0;
      edges  <= '0;
      o_time <= '0;
      o_done <= 1'b0;
    end else begin
      o_done <= 1'b0;
      if (i_start) begin
        busy   <= 1'b1;
        edges  <= '0;
        o_time <= '0;
      end else if (busy) begin
        if (i_tick) begin
          // long period counts may overflow; the count simply wraps
          o_time <= o_time + 1'b1;
        end
        if (osc_rise) begin
          if (edges == i_periods - 1'b1) begin
            busy   <= 1'b0;
            o_done <= 1'b1;
          end else begin
            edges <= edges + 1'b1;
          end
        end
      end
    end
  end
endmodule

// file: sim/mag_meas_monitor.sv
module mag_meas_monitor #(
  parameter int HS_DIV = 10
) (
  input wire logic       i_clock,
  input wire logic       i_rst_n,
  input wire logic       i_sclk,
  input wire logic       i_mosi,
  input wire logic       i_device_select_n,
  input wire logic       i_reset,
  input wire logic [2:0] i_osc_comp,
  input wire logic       o_miso,
  input wire logic       o_miso_oe,
  input wire logic       o_result_ready,
  input wire logic       o_clock_test_output,
  input wire logic       o_bias_forward,
  input wire logic [2:0] o_osc_enable,
  input wire logic       o_idle
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_rst_n);
  // eight cycles covers the pin synchroniser latency
  property p_sel_oe;
    $stable(i_device_select_n)[*8] |-> o_miso_oe == !i_device_select_n;
  endproperty
  a_sel_oe: assert property (p_sel_oe)
    else $error("miso enable does not follow select");
  property p_ready_clear;
    i_reset[*8] |-> !o_result_ready && !o_miso;
  endproperty
  a_ready_clear: assert property (p_ready_clear)
    else $error("ready or miso set while reset pin held");
  property p_ready_hold;
    (o_result_ready && !i_reset)[*5] |=> o_result_ready;
  endproperty
  a_ready_hold: assert property (p_ready_hold)
    else $error("ready dropped without reset");
  property p_ctest_off;
    i_reset[*8] |-> o_clock_test_output;
  endproperty
  a_ctest_off: assert property (p_ctest_off)
    else $error("clock test pad low with test disabled");
  property p_ctest_run;
    // the pad is low for at most one tick period of the internal clock
    $fell(o_clock_test_output) |-> ##[1:HS_DIV] o_clock_test_output;
  endproperty
  a_ctest_run: assert property (p_ctest_run)
    else $error("clock test pad stuck low");
  property p_one_axis;
    $onehot0(o_osc_enable);
  endproperty
  a_one_axis: assert property (p_one_axis)
    else $error("more than one oscillator enabled");
  property p_rev_last;
    $rose(o_result_ready) |-> !o_bias_forward;
  endproperty
  a_rev_last: assert property (p_rev_last)
    else $error("measurement ended in forward bias");
  property p_idle_quiet;
    o_idle |-> o_osc_enable == 3'h0;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("idle while an oscillator runs");
  property p_miso_steady;
    (i_sclk && $past(i_sclk)) |-> $stable(o_miso);
  endproperty
  a_miso_steady: assert property (p_miso_steady)
    else $error("miso changed while serial clock high");
endmodule

bind mag_meas_top mag_meas_monitor #(.HS_DIV(HS_DIV)) u_mon (
  .i_clock            (i_clock),
  .i_rst_n            (i_rst_n),
  .i_sclk             (i_sclk),
  .i_mosi             (i_mosi),
  .i_device_select_n  (i_device_select_n),
  .i_reset            (i_reset),
  .i_osc_comp         (i_osc_comp),
  .o_miso             (o_miso),
  .o_miso_oe          (o_miso_oe),
  .o_result_ready     (o_result_ready),
  .o_clock_test_output(o_clock_test_output),
  .o_bias_forward     (o_bias_forward),
  .o_osc_enable       (o_osc_enable),
  .o_idle             (o_idle)
);

// file: sim/mag_host.sv
module mag_host (
  input  wire logic i_clock,
  input  wire logic i_miso,
  output logic      o_sclk,
  output logic      o_mosi,
  output logic      o_sel_n,
  output logic      o_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_sclk = 1'b0;
    o_mosi = 1'b0;
    o_sel_n = 1'b1;
    o_reset = 1'b0;
  end
  task automatic wait_n(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  // half periods of 8 cycles leave room for the pin synchroniser
  task automatic send(input logic [7:0] c);
    o_sel_n <= 1'b0;
    o_reset <= 1'b1;
    wait_n(12);
    o_reset <= 1'b0;
    wait_n(12);
    for (int i = 7; i >= 0; i--) begin
      o_mosi <= c[i];
      wait_n(8);
      o_sclk <= 1'b1;
      wait_n(8);
      o_sclk <= 1'b0;
    end
    wait_n(1);
  endtask
  task automatic release_bus();
    o_sel_n <= 1'b1;
  endtask
  task automatic read(output logic [15:0] r);
    for (int i = 0; i < 16; i++) begin
      wait_n(8);
      o_sclk <= 1'b1;
      r = {r[14:0], i_miso};
      wait_n(8);
      o_sclk <= 1'b0;
    end
  endtask
endmodule

// file: sim/test_magnetometer_spi_measurement.sv
module test_magnetometer_spi_measurement;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock;
  logic        rst_n = 1'b0;
  logic        sclk, mosi, sel_n, pin_reset;
  logic        miso, miso_w, miso_oe, ready, ctest, bias, idle;
  logic [2:0]  osc_en;
  logic [2:0]  comp = 3'h0;
  logic        osc = 1'b0;
  logic        ct_d = 1'b1;
  logic [31:0] seed = 32'd20741;
  int          hf = 2, hr = 3, hcnt = 0, tog = 0;
  int          n_mismatch = 0;
  int          n_checks = 0;

  // a released miso line shows the inverse of its last value
  assign miso_w = miso_oe ? miso : ~miso;

  mag_meas_top #(.HS_DIV(2)) dut (
    .i_clock            (clock),
    .i_rst_n            (rst_n),
    .i_sclk             (sclk),
    .i_mosi             (mosi),
    .i_device_select_n  (sel_n),
    .i_reset            (pin_reset),
    .i_osc_comp         (comp),
    .o_miso             (miso),
    .o_miso_oe          (miso_oe),
    .o_result_ready     (ready),
    .o_clock_test_output(ctest),
    .o_bias_forward     (bias),
    .o_osc_enable       (osc_en),
    .o_idle             (idle)
  );
  mag_host host (
    .i_clock(clock),
    .i_miso (miso_w),
    .o_sclk (sclk),
    .o_mosi (mosi),
    .o_sel_n(sel_n),
    .o_reset(pin_reset)
  );

  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // sensor: half period depends on bias; idle axes carry noise
  always @(posedge clock) begin
    if (hcnt == 0) begin
      osc <= ~osc;
      hcnt <= bias ? hf : hr;
    end else begin
      hcnt <= hcnt - 1;
    end
    comp <= (osc_en & {3{osc}}) | (~osc_en & 3'(rnd()));
    ct_d <= ctest;
    if (ctest != ct_d) tog <= tog + 1;
  end

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic logic [2:0] ax(input logic [1:0] a);
    return a == 2'h3 ? 3'h4 : a == 2'h2 ? 3'h2 : 3'h1;
  endfunction

  task automatic meas(input logic [7:0] c);
    logic [15:0] r;
    int n, e;
    hf = 2 + int'(rnd() % 4);
    hr = hf + 1 - 2 * int'(rnd() % 2);
    host.send(c);
    tog = 0;
    n = 0;
    while (ready !== 1'b1 && n < 60000) begin
      @(posedge clock);
      n++;
      if (n == 20) begin
        check(osc_en, ax(c[1:0]));
        check(bias, 1'b1);
      end
    end
    check(ready, 1'b1);
    check(tog > 4, c[7]);
    host.read(r);
    // period is 2*(h+1) cycles and a tick is 2 cycles; phase slack allowed
    e = (32 << c[6:4]) * (hf - hr);
    check(($signed(r) - e >= -12) && ($signed(r) - e <= 12), 1'b1);
    check(miso_oe, 1'b1);
    repeat (10) @(posedge clock);
    check(idle, 1'b1);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    logic [31:0] v;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (8) @(posedge clock);
    check(idle, 1'b0);
    for (int i = 0; i < 6; i++) begin
      v = rnd();
      meas({i[0], i[2:0], v[3], 1'b0, i[1:0]});
    end
    // the longest counts are only started, then cut off by the next reset
    for (int p = 6; p < 8; p++) begin
      host.send({1'b0, 3'(p), 4'h2});
      repeat (20) @(posedge clock);
      check(osc_en, 3'h2);
    end
    for (int d = 0; d < 2; d++) begin
      host.send({4'h0, 1'(d), 3'h7});
      repeat (200) @(posedge clock);
      check({ready, bias, osc_en}, {1'b0, 1'(d), 3'h4});
    end
    meas(8'h01);
    host.release_bus();
    repeat (10) @(posedge clock);
    check(miso_oe, 1'b0);
    stop_test();
  end

  initial begin
    repeat (80000) @(posedge clock);
    n_mismatch++;
    stop_test();
  end
endmodule
